//--- src/acs_pkg.sv
// Constants shared by the analog column clock select block
package acs_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int SEL_W = 2;
    localparam int DBLK_SEL_W = 3;
    localparam int NUM_DBLK = 8;
    localparam int MAX_COLS = 4;

    // Register offsets
    localparam logic [7:0] COL_SEL_OFFSET = 8'h60;
    localparam logic [7:0] SRC_CTRL_OFFSET = 8'h61;
    localparam logic [7:0] DIV_CTRL_OFFSET = 8'h6c;
    localparam logic [7:0] STATUS_OFFSET = 8'h6d;

    // Reset values
    localparam logic [7:0] COL_SEL_RESET = 8'h00;
    localparam logic [7:0] SRC_CTRL_RESET = 8'h00;
    localparam logic [7:0] DIV_CTRL_RESET = 8'h00;

    // Column selector field positions
    localparam int COL0_LSB = 0;
    localparam int COL1_LSB = 2;
    localparam int COL2_LSB = 4;
    localparam int COL3_LSB = 6;

    // Analog clock source fields
    localparam int ANALOG_CLOCK_ZERO_LSB = 0;
    localparam int ANALOG_CLOCK_ONE_LSB = 3;
    localparam int SHDIS_BIT = 6;
    localparam logic [7:0] SRC_CTRL_MASK = 8'h7f;

    // Implemented selector bits per variant
    localparam logic [7:0] COL_MASK_4 = 8'hff;
    localparam logic [7:0] COL_MASK_2 = 8'h0f;
    localparam logic [7:0] COL_MASK_1 = 8'h0c;
    localparam logic [7:0] DIV_CTRL_MASK = 8'h0f;

    // Two source edges per half period gives divide by four
    localparam logic [1:0] FIXED_HALF = 2'h1;

    typedef enum logic [1:0] {
        SRC_VC1 = 2'b00,
        SRC_VC2 = 2'b01,
        SRC_ANALOG_CLOCK_ZERO = 2'b10,
        SRC_ANALOG_CLOCK_ONE = 2'b11
    } acs_src_t;
endpackage

//--- src/acs_src_mux.sv
// Analog clock source picked from one digital block primary output
`timescale 1ns/1ps
module acs_src_mux (
    input wire logic clk,
    input wire logic rst,
    input wire logic [acs_pkg::NUM_DBLK-1:0] blockOut,
    input wire logic [acs_pkg::DBLK_SEL_W-1:0] blockSel,
    output logic analogClock
);
    logic aclk_q;
    wire logic pickedLevel = blockOut[blockSel];

    always_ff @(posedge clk) begin
        if (rst) begin
            aclk_q <= 1'b0;
        end else begin
            aclk_q <= pickedLevel;
        end
    end

    assign analogClock = aclk_q;

    a_aclk_follows_block: assert property (@(posedge clk) disable iff (rst)
        !$past(rst) |-> aclk_q == $past(blockOut[blockSel]))
        else $error("analog clock does not follow selected block output");
endmodule // acs_src_mux

//--- src/acs_col_div.sv
// Column clock divider counting rising edges of the chosen source
`timescale 1ns/1ps
module acs_col_div (
    input wire logic clk,
    input wire logic rst,
    input wire logic active,
    input wire logic srcLevel,
    input wire logic [1:0] halfCount,
    output logic colClk
);
    logic srcPrev_q;
    logic [1:0] edgeCnt_q;
    logic colClk_q;
    wire logic srcRise = srcLevel & ~srcPrev_q;
    wire logic halfDone = edgeCnt_q >= halfCount;

    always_ff @(posedge clk) begin
        if (rst || !active) begin
            srcPrev_q <= 1'b0;
            edgeCnt_q <= 2'h0;
            colClk_q <= 1'b0;
        end else begin
            srcPrev_q <= srcLevel;
            if (srcRise && halfDone) begin
                edgeCnt_q <= 2'h0;
                colClk_q <= ~colClk_q;
            end else if (srcRise) begin
                edgeCnt_q <= edgeCnt_q + 2'h1;
            end
        end
    end

    assign colClk = colClk_q;

    a_toggle_on_edge: assert property (@(posedge clk) disable iff (rst)
        $changed(colClk_q) && active |-> $past(srcRise) && $past(halfDone))
        else $error("column clock toggled without its source edge");

    a_idle_held_low: assert property (@(posedge clk) disable iff (rst)
        !active |=> !colClk_q)
        else $error("inactive column clock is not low");
endmodule // acs_col_div

//--- src/acs_top.sv
// Analog column clock select: register port, source selection, column dividers
//
// Local design decision: the strobed register port.
`timescale 1ns/1ps
// How it works
// - Bits 7:6 pick column 3's clock: 00b clock one, 01b clock two, 10b analog zero, 11b analog one.
// - Bits 5:4 pick column 2's clock with the same four-way code.
// - Bits 3:2 pick column 1's clock with the same four-way code.
// - Bits 1:0 pick column 0's clock with the same four-way code.
// - Each column clock is its chosen source divided by four, except in the limited variant.
// - In the limited two-column variant the division comes from the divider control register.
// - Smaller variants keep only some selectors: two columns keep 1 and 0, one column keeps 1.
// - Each analog clock is a digital block output chosen by its own three-bit selector.
module acs_top #(
    parameter int NUM_COLUMNS = 4,
    parameter bit LIMITED = 1'b0
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [acs_pkg::ADDR_W-1:0] addr,
    input wire logic [acs_pkg::DATA_W-1:0] wrData,
    input wire logic wrStrobe,
    input wire logic rdStrobe,
    output logic [acs_pkg::DATA_W-1:0] rdData,
    input wire logic variableClockOne,
    input wire logic variableClockTwo,
    input wire logic [acs_pkg::NUM_DBLK-1:0] digBlockOut,
    output logic [acs_pkg::MAX_COLS-1:0] colClk
);
    generate
        if (!(NUM_COLUMNS == 4 || NUM_COLUMNS == 2 || NUM_COLUMNS == 1)) begin : g_bad_cols
            $error("NUM_COLUMNS must be 1, 2 or 4");
        end
        if (LIMITED && NUM_COLUMNS != 2) begin : g_bad_limited
            $error("LIMITED applies only to the two-column variant");
        end
    endgenerate

    // Implemented selector bits for this variant
    localparam logic [7:0] SEL_MASK = (NUM_COLUMNS == 4) ? acs_pkg::COL_MASK_4 :
        (NUM_COLUMNS == 2) ? acs_pkg::COL_MASK_2 : acs_pkg::COL_MASK_1;
    localparam logic [7:0] DIV_MASK = LIMITED ? acs_pkg::DIV_CTRL_MASK : 8'h00;

    function automatic logic pickSource(
        input logic [1:0] sel,
        input logic [3:0] sources
    );
        logic picked;
        picked = 1'b0;
        unique case (acs_pkg::acs_src_t'(sel))
            acs_pkg::SRC_VC1: picked = sources[0];
            acs_pkg::SRC_VC2: picked = sources[1];
            acs_pkg::SRC_ANALOG_CLOCK_ZERO: picked = sources[2];
            acs_pkg::SRC_ANALOG_CLOCK_ONE: picked = sources[3];
        endcase
        return picked;
    endfunction

    logic [7:0] analogColumnClockSelect_q;
    logic [7:0] analogColumnClockSelect_d;
    logic [7:0] analogClockSourceControl_q;
    logic [7:0] analogClockSourceControl_d;
    logic [7:0] columnDividerControl_q;
    logic [7:0] columnDividerControl_d;
    logic [7:0] rdData_q;
    logic [7:0] rdData_d;
    logic analogClockZero;
    logic analogClockOne;
    logic [3:0] colClkInt;
    logic [3:0] colClk_q;

    // Address decode
    wire logic hitColSel = addr == acs_pkg::COL_SEL_OFFSET;
    wire logic hitSrcCtrl = addr == acs_pkg::SRC_CTRL_OFFSET;
    wire logic hitDivCtrl = LIMITED && addr == acs_pkg::DIV_CTRL_OFFSET;
    wire logic hitStatus = addr == acs_pkg::STATUS_OFFSET;
    wire logic wrColSel = wrStrobe && hitColSel;
    wire logic wrSrcCtrl = wrStrobe && hitSrcCtrl;
    wire logic wrDivCtrl = wrStrobe && hitDivCtrl;

    // Selector fields
    wire logic [1:0] col0ClockSel = analogColumnClockSelect_q[acs_pkg::COL0_LSB +: acs_pkg::SEL_W];
    wire logic [1:0] col1ClockSel = analogColumnClockSelect_q[acs_pkg::COL1_LSB +: acs_pkg::SEL_W];
    wire logic [1:0] col2ClockSel = analogColumnClockSelect_q[acs_pkg::COL2_LSB +: acs_pkg::SEL_W];
    wire logic [1:0] col3ClockSel = analogColumnClockSelect_q[acs_pkg::COL3_LSB +: acs_pkg::SEL_W];
    wire logic [2:0] aclk0Sel =
        analogClockSourceControl_q[acs_pkg::ANALOG_CLOCK_ZERO_LSB +: acs_pkg::DBLK_SEL_W];
    wire logic [2:0] aclk1Sel =
        analogClockSourceControl_q[acs_pkg::ANALOG_CLOCK_ONE_LSB +: acs_pkg::DBLK_SEL_W];
    wire logic [3:0] sources = {analogClockOne, analogClockZero, variableClockTwo,
        variableClockOne};

    // Reserved bits are dropped on write
    assign analogColumnClockSelect_d = wrColSel ? (wrData & SEL_MASK) :
        analogColumnClockSelect_q;
    assign analogClockSourceControl_d = wrSrcCtrl ? (wrData & acs_pkg::SRC_CTRL_MASK) :
        analogClockSourceControl_q;
    assign columnDividerControl_d = wrDivCtrl ? (wrData & DIV_MASK) :
        columnDividerControl_q;

    // Read multiplexer, unmapped reads return zero
    wire logic [7:0] statusWord = {analogClockOne, analogClockZero, 2'b00, colClk_q};
    assign rdData_d = !rdStrobe ? 8'h00 :
        hitColSel ? analogColumnClockSelect_q :
        hitSrcCtrl ? analogClockSourceControl_q :
        hitDivCtrl ? columnDividerControl_q :
        hitStatus ? statusWord : 8'h00;

    always_ff @(posedge clk) begin
        if (rst) begin
            analogColumnClockSelect_q <= acs_pkg::COL_SEL_RESET;
            analogClockSourceControl_q <= acs_pkg::SRC_CTRL_RESET;
            columnDividerControl_q <= acs_pkg::DIV_CTRL_RESET;
            rdData_q <= 8'h00;
            colClk_q <= 4'h0;
        end else begin
            analogColumnClockSelect_q <= analogColumnClockSelect_d;
            analogClockSourceControl_q <= analogClockSourceControl_d;
            columnDividerControl_q <= columnDividerControl_d;
            rdData_q <= rdData_d;
            colClk_q <= colClkInt;
        end
    end

    assign rdData = rdData_q;
    assign colClk = colClk_q;

    acs_src_mux u_analog_clock_zero (
        .clk(clk),
        .rst(rst),
        .blockOut(digBlockOut),
        .blockSel(aclk0Sel),
        .analogClock(analogClockZero)
    );

    acs_src_mux u_analog_clock_one (
        .clk(clk),
        .rst(rst),
        .blockOut(digBlockOut),
        .blockSel(aclk1Sel),
        .analogClock(analogClockOne)
    );

    // One divider per column; absent columns stay low
    genvar c;
    generate
        for (c = 0; c < acs_pkg::MAX_COLS; c++) begin : g_col
            wire logic [1:0] sel = analogColumnClockSelect_q[2*c +: 2];
            wire logic selected = pickSource(sel, sources);
            wire logic [1:0] half = LIMITED ? columnDividerControl_q[2*c +: 2] :
                acs_pkg::FIXED_HALF;
            acs_col_div u_div (
                .clk(clk),
                .rst(rst),
                .active(SEL_MASK[2*c]),
                .srcLevel(selected),
                .halfCount(half),
                .colClk(colClkInt[c])
            );
        end
    endgenerate

    // Checking helpers: source edges seen by column 1 between toggles
    logic helpPrev_q;
    logic [3:0] helpCnt_q;
    logic [3:0] helpCnt_d;
    wire logic helpRise = g_col[1].selected & ~helpPrev_q;
    wire logic helpToggle = colClkInt[1] != colClk_q[1];
    assign helpCnt_d = (helpToggle ? 4'h0 : helpCnt_q) + {3'b000, helpRise};

    always_ff @(posedge clk) begin
        if (rst) begin
            helpPrev_q <= 1'b0;
            helpCnt_q <= 4'h0;
        end else begin
            helpPrev_q <= g_col[1].selected;
            helpCnt_q <= helpCnt_d;
        end
    end

    sequence s_col_sel_write;
        wrStrobe && hitColSel;
    endsequence

    sequence s_read_col_sel;
        rdStrobe && hitColSel;
    endsequence

    generate
        if (NUM_COLUMNS == 4) begin : g_chk4
            a_col3_field_load: assert property (@(posedge clk) disable iff (rst)
                s_col_sel_write |=> col3ClockSel == $past(wrData[7:6]))
                else $error("column 3 selector not loaded from bits 7:6");
            a_col2_field_load: assert property (@(posedge clk) disable iff (rst)
                s_col_sel_write |=> col2ClockSel == $past(wrData[5:4]))
                else $error("column 2 selector not loaded from bits 5:4");
            a_col3_analog_clock_one_route: assert property (@(posedge clk) disable iff (rst)
                col3ClockSel == 2'b11 |-> g_col[3].selected == analogClockOne)
                else $error("column 3 code 11b does not pick analog clock one");
        end
        if (NUM_COLUMNS >= 2) begin : g_chk2
            a_col0_field_load: assert property (@(posedge clk) disable iff (rst)
                s_col_sel_write |=> col0ClockSel == $past(wrData[1:0]))
                else $error("column 0 selector not loaded from bits 1:0");
        end
        if (!LIMITED) begin : g_chk_fixed
            a_fixed_div_four: assert property (@(posedge clk) disable iff (rst)
                helpToggle |-> helpCnt_d == 4'h0 && helpCnt_q + {3'b000, helpRise} == 4'h2)
                else $error("column 1 toggled after other than two source edges");
        end else begin : g_chk_limited
            a_limited_div_load: assert property (@(posedge clk) disable iff (rst)
                wrStrobe && addr == acs_pkg::DIV_CTRL_OFFSET |=>
                g_col[1].half == $past(wrData[3:2]))
                else $error("limited divider field not loaded");
        end
    endgenerate

    a_col1_field_load: assert property (@(posedge clk) disable iff (rst)
        s_col_sel_write ##1 !wrStrobe |-> col1ClockSel == $past(wrData[3:2]))
        else $error("column 1 selector not loaded from bits 3:2");

    a_col1_vc2_route: assert property (@(posedge clk) disable iff (rst)
        col1ClockSel == 2'b01 |-> g_col[1].selected == variableClockTwo)
        else $error("column 1 code 01b does not pick variable clock two");

    a_reserved_read_zero: assert property (@(posedge clk) disable iff (rst)
        s_read_col_sel |=> (rdData & ~SEL_MASK) == 8'h00)
        else $error("reserved selector bits read nonzero");

    a_absent_col_low: assert property (@(posedge clk) disable iff (rst)
        ##1 (colClk & ~{SEL_MASK[6], SEL_MASK[4], SEL_MASK[2], SEL_MASK[0]}) == 4'h0)
        else $error("absent column drives a clock");

    a_reset_clears_sel: assert property (@(posedge clk)
        rst |=> analogColumnClockSelect_q == 8'h00 && colClk == 4'h0)
        else $error("selectors not cleared by reset");

    a_read_one_cycle: assert property (@(posedge clk) disable iff (rst)
        !rdStrobe |=> rdData == 8'h00)
        else $error("read data stands outside its cycle");
endmodule // acs_top

//--- verification/acs_top_tb.sv
// Self-checking bench for the analog column clock select block
`timescale 1ns/1ps
module acs_top_tb;
    logic clk, rst, wrStrobe, rdStrobe;
    logic variableClockOne, variableClockTwo;
    logic [7:0] addr, wrData, digBlockOut, rd4, rdL, rd1;
    logic [7:0] wdLim, wdOne;
    logic [3:0] ccAll [3];
    wire [3:0] cc4, ccL, cc1;
    int errTotal, comparisons, tick, cyc;
    int srcPer [4] = '{2, 4, 6, 12};

    // Software keeps reserved bits of the smaller variants at zero
    assign wdLim = wrData & (addr == 8'h60 ? acs_pkg::COL_MASK_2 :
        (addr == 8'h6c ? acs_pkg::DIV_CTRL_MASK : 8'h00));
    assign wdOne = wrData & (addr == 8'h60 ? acs_pkg::COL_MASK_1 : 8'h00);

    always_comb ccAll = '{cc4, ccL, cc1};

    acs_top dut (.clk(clk), .rst(rst), .addr(addr),
        .wrData(wrData), .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData(rd4),
        .variableClockOne(variableClockOne), .variableClockTwo(variableClockTwo),
        .digBlockOut(digBlockOut), .colClk(cc4));
    acs_top #(.NUM_COLUMNS(2), .LIMITED(1'b1)) dutLim (.clk(clk), .rst(rst), .addr(addr),
        .wrData(wdLim), .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData(rdL),
        .variableClockOne(variableClockOne), .variableClockTwo(variableClockTwo),
        .digBlockOut(digBlockOut), .colClk(ccL));
    acs_top #(.NUM_COLUMNS(1), .LIMITED(1'b0)) dutOne (.clk(clk), .rst(rst), .addr(addr),
        .wrData(wdOne), .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData(rd1),
        .variableClockOne(variableClockOne), .variableClockTwo(variableClockTwo),
        .digBlockOut(digBlockOut), .colClk(cc1));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // Sources: periods 2 and 4, block k period 2(k+1)
    always @(posedge clk) begin
        cyc <= cyc + 1;
        variableClockOne <= ~variableClockOne;
        if (cyc % 2 == 1) variableClockTwo <= ~variableClockTwo;
        for (int k = 0; k < 8; k++) if (cyc % (k + 1) == k) digBlockOut[k] <= ~digBlockOut[k];
    end

    always @(posedge clk) begin
        tick <= tick + 1;
        if (tick == 20000) begin
            errTotal++;
            give_verdict();
        end
    end

    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", comparisons, errTotal);
        if (errTotal == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errTotal++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wrData <= d;
        wrStrobe <= 1'b1;
        @(posedge clk);
        wrStrobe <= 1'b0;
    endtask

    task automatic reg_read(input logic [7:0] a, output logic [7:0] d4, dl, d1);
        @(posedge clk);
        addr <= a;
        rdStrobe <= 1'b1;
        @(posedge clk);
        rdStrobe <= 1'b0;
        #1;
        d4 = rd4;
        dl = rdL;
        d1 = rd1;
    endtask

    // Clock cycles between the third and fourth rising edge of a column clock
    task automatic measure(input int v, input int c, output logic [15:0] per);
        logic prev;
        int e, t0;
        per = 16'h0000;
        e = 0;
        t0 = 0;
        prev = ccAll[v][c];
        for (int n = 0; n < 600 && e < 4; n++) begin
            @(posedge clk);
            #1;
            if (ccAll[v][c] === 1'b1 && prev !== 1'b1) begin
                e++;
                if (e == 3) t0 = n;
                if (e == 4) per = 16'(n - t0);
            end
            prev = ccAll[v][c];
        end
    endtask

    task automatic do_reset();
        rst <= 1'b1;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        #1;
        check("colClk in reset", 16'({ccAll[0], ccAll[1], ccAll[2]}), 16'h0000);
    endtask

    task automatic t_reset_values();
        logic [7:0] a, b, c;
        reg_read(8'h60, a, b, c);
        check("select 4col", 16'(a), 16'h0000);
        check("select limited", 16'(b), 16'h0000);
        check("select 1col", 16'(c), 16'h0000);
        reg_read(8'h6c, a, b, c);
        check("divider limited", 16'(b), 16'h0000);
    endtask

    task automatic t_regs();
        logic [7:0] a, b, c;
        reg_write(8'h60, 8'h1b);
        reg_read(8'h60, a, b, c);
        check("select 4col", 16'(a), 16'h001b);
        check("select limited", 16'(b), 16'h000b);
        check("select 1col", 16'(c), 16'h0008);
    endtask

    task automatic t_select();
        logic [7:0] v, r4, rl, r1;
        logic [15:0] p;
        reg_write(8'h61, 8'h2a);
        reg_read(8'h61, r4, rl, r1);
        check("source control 4col", 16'(r4), 16'h002a);
        for (int k = 0; k < 4; k++) begin
            v = 8'h00;
            for (int c = 0; c < 4; c++) v[2*c +: 2] = 2'((c + k) % 4);
            reg_write(8'h60, v);
            for (int c = 0; c < 4; c++) begin
                measure(0, c, p);
                check("column period", p, 16'(4 * srcPer[(c + k) % 4]));
            end
            if ((1 + k) % 4 < 2) begin
                measure(2, 1, p);
                check("1col period", p, 16'(4 * srcPer[(1 + k) % 4]));
            end
            check("1col absent", 16'(ccAll[2] & 4'hd), 16'h0000);
        end
    endtask

    task automatic t_limited();
        logic [7:0] a, b, c;
        logic [15:0] p;
        reg_write(8'h60, 8'h04);
        measure(1, 0, p);
        check("limited col0 div2", p, 16'h0004);
        measure(0, 0, p);
        check("fixed col0 div4", p, 16'h0008);
        reg_write(8'h6c, 8'h0b);
        reg_read(8'h6c, a, b, c);
        check("divider limited", 16'(b), 16'h000b);
        check("divider absent", 16'(a), 16'h0000);
        measure(1, 0, p);
        check("limited col0 div8", p, 16'h0010);
        measure(1, 1, p);
        check("limited col1 div6", p, 16'h0018);
        check("limited absent", 16'(ccAll[1][3:2]), 16'h0000);
    endtask

    initial begin
        rst = 1'b1;
        wrStrobe = 1'b0;
        rdStrobe = 1'b0;
        addr = 8'h00;
        wrData = 8'h00;
        variableClockOne = 1'b0;
        variableClockTwo = 1'b0;
        digBlockOut = 8'h00;
        errTotal = 0;
        comparisons = 0;
        tick = 0;
        cyc = 0;
        do_reset();
        t_reset_values();
        t_regs();
        t_select();
        t_limited();
        @(posedge clk);
        do_reset();
        t_reset_values();
        give_verdict();
    end
endmodule // acs_top_tb
